// >>> verilog/smsp_pkg.sv
// constants, field layout and mode type of the switch monitor serial slave
// assumes every user writes smsp_pkg::name; nothing is imported
package smsp_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [4:0] FRAME_FULL = 5'h18;
  localparam int SP_COUNT = 8;
  localparam int SG_COUNT = 14;
  localparam int SW_COUNT = 22;
  localparam int SG_LSB = 0;
  localparam int SP_LSB = 14;
  localparam int RESET_FLAG_BIT = 22;
  localparam int THERMAL_BIT = 23;
  localparam int CMD_CODE_MSB = 23;
  localparam int CMD_CODE_LSB = 16;
  localparam logic [7:0] CMD_SETTINGS = 8'h01;
  localparam logic [7:0] POLARITY_RESET = 8'hFF;
  localparam logic [23:0] CMD_RESET = 24'h000000;
  // synchronised pin vector layout
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_INT = 3;
  localparam int PIN_WAKE = 4;
  localparam int PIN_VDD = 5;
  localparam int PIN_W = 6;
  localparam logic [5:0] PIN_RESET = 6'h19;
  localparam logic [21:0] SW_RESET = 22'h000000;
  typedef enum logic {MODE_NORMAL, MODE_SLEEP} smsp_mode_t;
endpackage

// >>> verilog/smsp_link_if.sv
// shift engine link between the frame controller and the shift register
// assumes one clock domain; edge strobes are already synchronised and gated
`timescale 1ns/1ps
interface smsp_link_if;
  logic sclkRise;
  logic sclkFall;
  logic siBit;
  logic load;
  logic [23:0] loadWord;
  logic soBit;
  logic [23:0] rxWord;
  logic [4:0] bitCount;
  modport engine (input sclkRise, sclkFall, siBit, load, loadWord, output soBit, rxWord, bitCount);
  modport ctrl (output sclkRise, sclkFall, siBit, load, loadWord, input soBit, rxWord, bitCount);
endinterface

// >>> verilog/smsp_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes inputs may change at any time relative to ref_clk
`timescale 1ns/1ps
module smsp_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pins in, filtered levels out
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] stage1, stage2, stage3, filt;
  logic [W-1:0] next_filt;

  // a bit changes only once stages two and three agree; stage one feeds stage two only
  always_comb begin
    next_filt = (stage2 & stage3) | (filt & (stage2 ^ stage3));
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      filt <= RESET_VAL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      filt <= next_filt;
    end
  end

  assign pinOut = filt;
endmodule

// >>> verilog/smsp_shift_engine.sv
// shared 24-bit shift register: status out on clock rise, command in on fall
// assumes edge strobes arrive only while chip select is low
`timescale 1ns/1ps
module smsp_shift_engine (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link to the frame controller
  smsp_link_if.engine lnk
);
  logic [23:0] shreg, next_shreg;
  logic soBit, next_soBit;
  logic [4:0] count, next_count;

  // load wins over shifting; count saturates so daisy-chained frames keep the last word
  always_comb begin
    next_shreg = shreg;
    next_soBit = soBit;
    next_count = count;
    if (lnk.load) begin
      next_shreg = lnk.loadWord;
      next_count = 5'h00;
    end else begin
      if (lnk.sclkRise) begin
        next_soBit = shreg[smsp_pkg::FRAME_BITS-1];
      end
      if (lnk.sclkFall) begin
        next_shreg = {shreg[smsp_pkg::FRAME_BITS-2:0], lnk.siBit};
        if (count != smsp_pkg::FRAME_FULL) begin
          next_count = count + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shreg <= 24'h000000;
      soBit <= 1'b0;
      count <= 5'h00;
    end else begin
      shreg <= next_shreg;
      soBit <= next_soBit;
      count <= next_count;
    end
  end

  assign lnk.soBit = soBit;
  assign lnk.rxWord = shreg;
  assign lnk.bitCount = count;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_sample_si;
    lnk.sclkFall && !lnk.load |=> shreg[0] == $past(lnk.siBit);
  endproperty
  a_sample_si: assert property (p_sample_si) else $error("input bit not sampled on clock fall");

  property p_present_msb;
    lnk.sclkRise && !lnk.load |=> lnk.soBit == $past(shreg[23]);
  endproperty
  a_present_msb: assert property (p_present_msb) else $error("output bit not presented on clock rise");

  property p_msb_first;
    lnk.sclkFall && !lnk.load |=> shreg[23:1] == $past(shreg[22:0]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("shift register not moving toward msb");
endmodule

// >>> verilog/smsp_switch_monitor_serial_slave.sv
// serial slave port, interrupt and wake control of a 22-input switch monitor
// assumes pins and comparator outputs are asynchronous; power-on reset drives rst
`timescale 1ns/1ps
module smsp_switch_monitor_serial_slave (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial port pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic soOeN,
  // interrupt pin, open-drain
  input wire logic intLineN,
  output logic intOut,
  output logic intOeN,
  // wake pin, open-drain
  input wire logic wakeLineN,
  output logic wakeOut,
  output logic wakeOeN,
  // logic supply and comparator outputs (1 = above threshold)
  input wire logic vddPresent,
  input wire logic [7:0] polarity_programmable_inputs,
  input wire logic [13:0] ground_only_inputs,
  // core controls on this clock
  input wire logic [21:0] changeIntEnable,
  input wire logic sleepRequest,
  input wire logic thermalFlag,
  // command and status towards the core
  output logic [23:0] cmdWord,
  output logic cmdStrobe,
  output logic frameIntLatched,
  output logic modeSleep
);
  logic [smsp_pkg::PIN_W-1:0] pinRaw, pinF;
  logic [21:0] swRaw, swF;
  smsp_link_if lnk ();

  assign pinRaw = {vddPresent, wakeLineN, intLineN, si, sclk, csN};
  assign swRaw = {polarity_programmable_inputs, ground_only_inputs};

  smsp_pin_sync #(.W(smsp_pkg::PIN_W), .RESET_VAL(smsp_pkg::PIN_RESET)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(pinRaw),
    .pinOut(pinF)
  );

  smsp_pin_sync #(.W(smsp_pkg::SW_COUNT), .RESET_VAL(smsp_pkg::SW_RESET)) u_sw_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn(swRaw),
    .pinOut(swF)
  );

  smsp_shift_engine u_shift (
    .ref_clk(ref_clk),
    .rst(rst),
    .lnk(lnk)
  );

  // open switch reads 0, closed 1; polarity bit 1 means switch to battery
  function automatic logic [21:0] closed_map(input logic [21:0] above, input logic [7:0] pol);
    logic [21:0] res;
    res[smsp_pkg::SG_LSB +: smsp_pkg::SG_COUNT] = ~above[smsp_pkg::SG_LSB +: smsp_pkg::SG_COUNT];
    res[smsp_pkg::SP_LSB +: smsp_pkg::SP_COUNT] = (above[smsp_pkg::SP_LSB +: smsp_pkg::SP_COUNT] & pol)
      | (~above[smsp_pkg::SP_LSB +: smsp_pkg::SP_COUNT] & ~pol);
    return res;
  endfunction

  // state
  logic csPrev, sclkPrev, intPrev, wakePrev;
  logic next_csPrev, next_sclkPrev, next_intPrev, next_wakePrev;
  logic [21:0] closedPrev, next_closedPrev;
  logic primed, next_primed;
  logic [7:0] polarity, next_polarity;
  logic resetFlag, next_resetFlag;
  logic [23:0] next_cmdWord;
  logic next_cmdStrobe, next_frameIntLatched, next_soOeN;
  smsp_pkg::smsp_mode_t mode, next_mode;
  logic intAssert, next_intAssert;
  logic chgInFrame, next_chgInFrame;
  logic next_intOeN, next_wakeOeN;

  // decoded events
  logic csHigh, vdd, intHigh, wakeHigh;
  logic csFall, csRise, intFall, wakeFall;
  logic [21:0] closedNow;
  logic anyChange;

  assign csHigh = pinF[smsp_pkg::PIN_CS];
  assign vdd = pinF[smsp_pkg::PIN_VDD];
  assign intHigh = pinF[smsp_pkg::PIN_INT];
  assign wakeHigh = pinF[smsp_pkg::PIN_WAKE];
  assign csFall = csPrev & ~csHigh;
  assign csRise = ~csPrev & csHigh;
  assign intFall = intPrev & ~intHigh;
  assign wakeFall = wakePrev & ~wakeHigh;
  assign closedNow = closed_map(swF, polarity);
  assign anyChange = primed & (|((closedNow ^ closedPrev) & changeIntEnable));

  // serial clock edges count only inside a frame; the host keeps sclk low around cs edges
  assign lnk.sclkRise = ~csHigh & ~csFall & ~sclkPrev & pinF[smsp_pkg::PIN_SCLK];
  assign lnk.sclkFall = ~csHigh & ~csFall & sclkPrev & ~pinF[smsp_pkg::PIN_SCLK];
  assign lnk.siBit = pinF[smsp_pkg::PIN_SI];
  assign lnk.load = csFall;
  assign lnk.loadWord = {thermalFlag, resetFlag, closedNow};

  // frame group: edge history, status capture, command activation
  always_comb begin
    next_csPrev = csHigh;
    next_sclkPrev = pinF[smsp_pkg::PIN_SCLK];
    next_intPrev = intHigh;
    next_wakePrev = wakeHigh;
    next_closedPrev = closedNow;
    next_primed = 1'b1;
    next_polarity = polarity;
    next_resetFlag = resetFlag;
    next_cmdWord = cmdWord;
    next_cmdStrobe = 1'b0;
    next_frameIntLatched = frameIntLatched;
    next_soOeN = csHigh;
    if (csFall) begin
      next_frameIntLatched = intHigh;
    end
    if (csRise) begin
      next_resetFlag = 1'b0;
      // a short frame is dropped; a longer one keeps its last 24 bits
      if (lnk.bitCount == smsp_pkg::FRAME_FULL) begin
        next_cmdWord = lnk.rxWord;
        next_cmdStrobe = 1'b1;
        if (lnk.rxWord[smsp_pkg::CMD_CODE_MSB:smsp_pkg::CMD_CODE_LSB] == smsp_pkg::CMD_SETTINGS) begin
          next_polarity = lnk.rxWord[smsp_pkg::SP_COUNT-1:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      csPrev <= 1'b1;
      sclkPrev <= 1'b0;
      intPrev <= 1'b1;
      wakePrev <= 1'b1;
      closedPrev <= 22'h000000;
      primed <= 1'b0;
      polarity <= smsp_pkg::POLARITY_RESET;
      resetFlag <= 1'b1;
      cmdWord <= smsp_pkg::CMD_RESET;
      cmdStrobe <= 1'b0;
      frameIntLatched <= 1'b1;
      soOeN <= 1'b1;
    end else begin
      csPrev <= next_csPrev;
      sclkPrev <= next_sclkPrev;
      intPrev <= next_intPrev;
      wakePrev <= next_wakePrev;
      closedPrev <= next_closedPrev;
      primed <= next_primed;
      polarity <= next_polarity;
      resetFlag <= next_resetFlag;
      cmdWord <= next_cmdWord;
      cmdStrobe <= next_cmdStrobe;
      frameIntLatched <= next_frameIntLatched;
      soOeN <= next_soOeN;
    end
  end

  // mode and interrupt group
  always_comb begin
    next_mode = mode;
    next_intAssert = intAssert;
    next_chgInFrame = chgInFrame;
    case (mode)
      smsp_pkg::MODE_NORMAL: begin
        // sleep is entered only between frames
        if (sleepRequest && csHigh && !anyChange) begin
          next_mode = smsp_pkg::MODE_SLEEP;
        end
      end
      smsp_pkg::MODE_SLEEP: begin
        if (csFall && vdd) begin
          next_mode = smsp_pkg::MODE_NORMAL;
        end
        if (intFall && wakeHigh && vdd) begin
          next_mode = smsp_pkg::MODE_NORMAL;
        end
        if (wakeFall && (intHigh || !vdd)) begin
          next_mode = smsp_pkg::MODE_NORMAL;
        end
        if (anyChange) begin
          next_mode = smsp_pkg::MODE_NORMAL;
        end
      end
      default: next_mode = smsp_pkg::MODE_NORMAL;
    endcase
    // sticky in-frame change; a new frame restarts it, a change in that cycle still counts
    if (csFall) begin
      next_chgInFrame = 1'b0;
    end
    if (anyChange && !csHigh) begin
      next_chgInFrame = 1'b1;
    end
    if (csRise && !chgInFrame) begin
      next_intAssert = 1'b0;
    end
    // set wins over the end-of-frame clear
    if (anyChange && mode == smsp_pkg::MODE_NORMAL) begin
      next_intAssert = 1'b1;
    end
    next_intOeN = ~next_intAssert;
    next_wakeOeN = (next_mode == smsp_pkg::MODE_SLEEP);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode <= smsp_pkg::MODE_NORMAL;
      intAssert <= 1'b0;
      chgInFrame <= 1'b0;
      intOeN <= 1'b1;
      wakeOeN <= 1'b0;
      intOut <= 1'b0;
      wakeOut <= 1'b0;
      modeSleep <= 1'b0;
    end else begin
      mode <= next_mode;
      intAssert <= next_intAssert;
      chgInFrame <= next_chgInFrame;
      intOeN <= next_intOeN;
      wakeOeN <= next_wakeOeN;
      intOut <= 1'b0;
      wakeOut <= 1'b0;
      modeSleep <= (next_mode == smsp_pkg::MODE_SLEEP);
    end
  end

  assign so = lnk.soBit;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_cs_fall_load;
    csFall |=> !soOeN && frameIntLatched == $past(intHigh);
  endproperty
  a_cs_fall_load: assert property (p_cs_fall_load) else $error("frame start did not enable output or latch int");

  property p_cs_rise_off;
    csRise |=> soOeN;
  endproperty
  a_cs_rise_off: assert property (p_cs_rise_off) else $error("output not released after frame end");

  property p_idle_quiet;
    csHigh && csPrev |=> soOeN && $stable(lnk.rxWord);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while deselected");

  property p_int_clear;
    csRise && !chgInFrame && !anyChange |=> intOeN;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared at frame end");

  property p_int_hold;
    csRise && chgInFrame |=> !intOeN;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt cleared despite in-frame change");

  property p_int_set;
    mode == smsp_pkg::MODE_NORMAL && anyChange |=> !intOeN ##1 !intOeN;
  endproperty
  a_int_set: assert property (p_int_set) else $error("switch change did not assert interrupt");

  property p_reset_flag;
    csRise |=> !resetFlag;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset indication not cleared");

  property p_cs_wake;
    mode == smsp_pkg::MODE_SLEEP && csFall && vdd |=> mode == smsp_pkg::MODE_NORMAL && !wakeOeN;
  endproperty
  a_cs_wake: assert property (p_cs_wake) else $error("chip select fall did not wake");

  property p_int_wake;
    mode == smsp_pkg::MODE_SLEEP && intFall && wakeHigh && vdd |=> mode == smsp_pkg::MODE_NORMAL;
  endproperty
  a_int_wake: assert property (p_int_wake) else $error("interrupt line fall did not wake");

  property p_wake_pin;
    mode == smsp_pkg::MODE_SLEEP && wakeFall && (intHigh || !vdd) |=> !modeSleep && !wakeOeN;
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("wake pin fall did not wake");

  property p_no_vdd_wake;
    mode == smsp_pkg::MODE_SLEEP && !vdd && !wakeFall && !anyChange |=> mode == smsp_pkg::MODE_SLEEP;
  endproperty
  a_no_vdd_wake: assert property (p_no_vdd_wake) else $error("woke without logic supply");

  property p_cmd_take;
    csRise && lnk.bitCount == smsp_pkg::FRAME_FULL |=> cmdStrobe && cmdWord == $past(lnk.rxWord);
  endproperty
  a_cmd_take: assert property (p_cmd_take) else $error("full command word not activated");

  property p_cmd_short;
    csRise && lnk.bitCount != smsp_pkg::FRAME_FULL |=> !cmdStrobe && $stable(cmdWord);
  endproperty
  a_cmd_short: assert property (p_cmd_short) else $error("short frame activated a command");

  c_full_frame: cover property (csRise && lnk.bitCount == smsp_pkg::FRAME_FULL);
  c_cs_wake: cover property (mode == smsp_pkg::MODE_SLEEP && csFall && vdd);
  c_int_held: cover property (csRise && chgInFrame && intAssert);
endmodule

// >>> testbench/smsp_host_model.sv
// host controller model acting as serial bus master of the switch monitor
// assumes the slave samples its pins with ref_clk; link clock runs inside frames and, from idle_noise, while deselected
`timescale 1ns/1ps
module smsp_host_model (
  // clock
  input wire logic ref_clk,
  // slave serial output
  input wire logic so,
  input wire logic soOeN,
  // master pins
  output logic csN = 1'b1,
  output logic sclk = 1'b0,
  output logic si = 1'b0
);
  // one frame of nBits clocks at 160 ns; chip select moves only with sclk low
  task automatic frame(input logic [23:0] tx, input int nBits, output logic [23:0] rx, output logic oeOk);
    rx = '0;
    oeOk = 1'b1;
    @(posedge ref_clk);
    csN <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < nBits; i++) begin
      sclk <= 1'b1;
      si <= tx[23 - i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
      repeat (3) @(posedge ref_clk);
      // sample late in the low phase: slave output lags the pin by synchroniser delay
      @(negedge ref_clk);
      rx = {rx[22:0], so};
      oeOk = oeOk & (soOeN === 1'b0);
      @(posedge ref_clk);
    end
    repeat (8) @(posedge ref_clk);
    csN <= 1'b1;
    si <= ~si; // released line shows no stale value
  endtask

  // clock and data noise while deselected; breaks the quiet-idle habit on purpose
  task automatic idle_noise;
    for (int i = 0; i < 4; i++) begin
      sclk <= 1'b1;
      si <= ~si;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// >>> testbench/smsp_switch_monitor_serial_slave_test.sv
// self-checking bench of the switch monitor serial slave with a host model
// assumes 50 MHz ref_clk and the latencies given for the synchronised pins
`timescale 1ns/1ps
module smsp_switch_monitor_serial_slave_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic csN, sclk, si, so, soOeN, intOut, intOeN, wakeOut, wakeOeN, intLineN, wakeLineN;
  logic extIntN = 1'b1;
  logic extWakeN = 1'b1;
  logic vddPresent = 1'b1;
  logic [7:0] progIn = 8'hA5;
  logic [13:0] gndIn = 14'h1234;
  logic [21:0] changeIntEnable = 22'h3FFFFF;
  logic sleepRequest = 1'b0;
  logic thermalFlag = 1'b1;
  logic [23:0] cmdWord;
  logic cmdStrobe, frameIntLatched, modeSleep, oeOk;
  logic [23:0] rx;
  int errTotal = 0;
  int nTests = 0;
  int strobes = 0;
  int s0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // open-drain wires with pull-ups; another device may pull them low as well
  assign intLineN = (intOeN ? 1'b1 : intOut) & extIntN;
  assign wakeLineN = (wakeOeN ? 1'b1 : wakeOut) & extWakeN;

  // count strobes away from the launching edge so ordering never matters
  always @(negedge ref_clk) if (cmdStrobe === 1'b1) strobes++;

  smsp_switch_monitor_serial_slave dut (
    .ref_clk(ref_clk), .rst(rst), .csN(csN), .sclk(sclk), .si(si), .so(so), .soOeN(soOeN),
    .intLineN(intLineN), .intOut(intOut), .intOeN(intOeN), .wakeLineN(wakeLineN),
    .wakeOut(wakeOut), .wakeOeN(wakeOeN), .vddPresent(vddPresent),
    .polarity_programmable_inputs(progIn), .ground_only_inputs(gndIn),
    .changeIntEnable(changeIntEnable), .sleepRequest(sleepRequest), .thermalFlag(thermalFlag),
    .cmdWord(cmdWord), .cmdStrobe(cmdStrobe), .frameIntLatched(frameIntLatched), .modeSleep(modeSleep)
  );

  smsp_host_model host (.ref_clk(ref_clk), .so(so), .soOeN(soOeN), .csN(csN), .sclk(sclk), .si(si));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // expected status word; closed reads 1
  function automatic logic [23:0] status(input logic [7:0] pol, input logic rf);
    return {thermalFlag, rf, ~(progIn ^ pol), ~gndIn};
  endfunction

  task automatic xfer(input logic [23:0] tx, input int n);
    host.frame(tx, n, rx, oeOk);
    tick(12);
  endtask

  task automatic go_sleep;
    sleepRequest <= 1'b1;
    tick(1);
    sleepRequest <= 1'b0;
    tick(6);
    check(modeSleep, 1'b1);
    check(wakeOeN, 1'b1);
  endtask

  // looked at before the synchronisers flush: their first settled switch values count as a change
  task automatic t_reset;
    check(soOeN, 1'b1);
    check(intOeN, 1'b1);
    check(intOut, 1'b0);
    check(wakeOeN, 1'b0);
    check(wakeOut, 1'b0);
    check(modeSleep, 1'b0);
    check(cmdWord, 24'h000000);
  endtask

  // first frame loads polarity; second sees it and the cleared reset flag
  task automatic t_frames;
    s0 = strobes;
    xfer(24'h01000F, 24);
    check(rx, status(8'hFF, 1'b1));
    check(oeOk, 1'b1);
    check(soOeN, 1'b1);
    check(cmdWord, 24'h01000F);
    check(24'(strobes - s0), 24'h000001);
    xfer(24'hABCDEF, 24);
    check(rx, status(8'h0F, 1'b0));
    check(cmdWord, 24'hABCDEF);
    check(intOeN, 1'b1);
  endtask

  task automatic t_short;
    s0 = strobes;
    xfer(24'h123456, 23);
    check(frameIntLatched, 1'b1);
    check(cmdWord, 24'hABCDEF);
    check(24'(strobes - s0), 24'h000000);
  endtask

  task automatic t_idle;
    s0 = strobes;
    host.idle_noise();
    tick(12);
    check(24'(strobes - s0), 24'h000000);
    check(soOeN, 1'b1);
  endtask

  task automatic t_int;
    gndIn <= 14'h1235;
    tick(10);
    check(intOeN, 1'b0);
    xfer(24'hABCDEF, 24);
    check(frameIntLatched, 1'b0);
    check(intOeN, 1'b1);
    // a change while selected must survive the frame end
    gndIn <= 14'h1234;
    tick(10);
    fork
      xfer(24'hABCDEF, 24);
      begin
        tick(60);
        gndIn <= 14'h1236;
      end
    join
    check(intOeN, 1'b0);
    xfer(24'hABCDEF, 24);
    check(intOeN, 1'b1);
    changeIntEnable <= '0;
    gndIn <= 14'h1234;
    tick(10);
    check(intOeN, 1'b1);
  endtask

  task automatic t_sleep;
    go_sleep();
    xfer(24'h000000, 0);
    check(modeSleep, 1'b0);
    go_sleep();
    vddPresent <= 1'b0;
    xfer(24'h000000, 0);
    extIntN <= 1'b0;
    tick(10);
    check(modeSleep, 1'b1);
    extWakeN <= 1'b0;
    tick(10);
    check(modeSleep, 1'b0);
    check(wakeOeN, 1'b0);
    extWakeN <= 1'b1;
    extIntN <= 1'b1;
    vddPresent <= 1'b1;
    tick(10);
    go_sleep();
    extIntN <= 1'b0;
    tick(10);
    check(modeSleep, 1'b0);
    go_sleep();
    extWakeN <= 1'b0;
    tick(10);
    check(modeSleep, 1'b1);
    extWakeN <= 1'b1;
    extIntN <= 1'b1;
    tick(10);
    extWakeN <= 1'b0;
    tick(10);
    check(modeSleep, 1'b0);
    extWakeN <= 1'b1;
  endtask

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(2);
    t_reset();
    tick(6);
    t_frames();
    t_short();
    t_idle();
    t_int();
    t_sleep();
    giveVerdict();
  end

  // watchdog: the whole run needs well under 10000 cycles
  initial begin
    tick(30000);
    errTotal++;
    giveVerdict();
  end
endmodule
